/* logic/seic_arbiter.sv */
/*
 * Fixed-priority arbiter: picks the lowest-numbered requesting source.
 * Assumes inputs are already synchronous to the core clock.
 */
module seic_arbiter (
    input  wire logic [seic_pkg::NUM_SRC-1:0] req_in,    // Qualified requests.
    output logic                              any_out,   // Any request present.
    output logic [seic_pkg::IDX_W-1:0]        vec_out    // Winning vector index.
);
    import seic_pkg::*;

    // Scan from the lowest priority upward so the highest one wins last.
    always_comb begin
        any_out = 1'b0;
        vec_out = VEC_RESET;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req_in[i]) begin
                any_out = 1'b1;
                vec_out = SRC_VEC[i];
            end
        end
    end

endmodule // seic_arbiter

/* logic/seic_ctl.sv */
/*
 * Exception and low-power controller top. Latches and arbitrates interrupt
 * requests at instruction boundaries, supplies vector index and stacking
 * controls to the core, shows request flags over APB, protects module flags
 * in break and sequences wait and stop with clock gating.
 * Assumes the core gives a one-cycle instruction-complete strobe and decoded
 * instruction strobes, all synchronous to core_clk_in; requests from
 * peripherals and the break module are on the same clock.
 */
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
module seic_ctl (
    input  wire logic                          core_clk_in,        // Core clock.
    input  wire logic                          nrst_in,            // Sync reset, low.
    input  wire logic                          psel_in,            // APB select.
    input  wire logic                          penable_in,         // APB enable.
    input  wire logic                          pwrite_in,          // APB write.
    input  wire logic [7:0]                    paddr_in,           // APB byte address.
    input  wire logic [31:0]                   pwdata_in,          // APB write data.
    output logic                               pready_out,         // APB ready.
    output logic                               pslverr_out,        // APB error.
    output logic [31:0]                        prdata_out,         // APB read data.
    input  wire logic [seic_pkg::NUM_SRC-1:0]  irq_req_in,         // Hardware requests.
    input  wire logic                          sys_reset_req_in,   // Any reset source.
    input  wire logic                          break_req_in,       // Break request.
    input  wire logic                          insn_done_in,       // Instruction complete.
    input  wire logic                          soft_int_exec_in,   // Software interrupt op.
    input  wire logic                          wait_exec_in,       // Wait instruction.
    input  wire logic                          stop_exec_in,       // Stop instruction.
    input  wire logic                          rti_exec_in,        // Return from interrupt.
    input  wire logic                          stack_done_in,      // Stacking finished.
    output logic                               take_exc_out,       // Begin exception entry.
    output logic [seic_pkg::IDX_W-1:0]         vec_idx_out,        // Vector index held.
    output logic                               stack_pc_minus_out, // Stack PC-1.
    output logic                               stack_high_idx_out, // Stack high index.
    output logic                               global_mask_out,    // Global mask bit.
    output logic                               core_clk_en_out,    // Core clock gate.
    output logic                               periph_clk_en_out,  // Periph clock gate.
    output logic                               fast_clk_en_out,    // Fast clock gate.
    output logic                               watchdog_run_out,   // Watchdog may count.
    output logic                               break_state_out,    // In break.
    output logic                               flag_clear_ok_out   // Module flag clears ok.
);
    import seic_pkg::*;

    // Controller states.
    typedef enum logic [2:0] {
        SEIC_RUN, SEIC_ENTRY, SEIC_WAIT, SEIC_STOP, SEIC_RECOVER
    } seic_state_type;

    seic_state_type     state_ff;       // Current state.
    seic_state_type     nxt_state;      // Next state.
    logic [NUM_SRC-1:0] enable_ff;      // Per-source enables.
    logic [3:0]         control_ff;     // Control bits.
    logic               mask_ff;        // Global interrupt mask.
    logic               break_ff;       // Break state active.
    logic               bsw_flag_ff;    // Break during wait or stop.
    logic [IDX_W-1:0]   vec_ff;         // Held vector index.
    logic               pc_minus_ff;    // Hardware entry stacks PC-1.
    logic               take_ff;        // Entry pulse.
    logic [31:0]        rdata_ff;       // Registered read data.
    logic [NUM_SRC-1:0] qual_req;       // Enabled, unmasked requests.
    logic               hw_any;         // Some qualified request.
    logic [IDX_W-1:0]   hw_vec;         // Winning hardware vector.
    logic               rec_done;       // Stop recovery elapsed.
    logic [7:0]         flag_one;       // First status image.
    logic [7:0]         flag_two;       // Second status image.
    logic [7:0]         flag_three;     // Third status image.
    logic               wr_en;          // APB write strobe.
    logic               rd_en;          // APB read strobe.
    logic               addr_ok;        // Address decodes.
    logic               wake;           // Wake event in low power.

    // Requests are qualified by their enables and the global mask. A return
    // reopens the mask, so a request still pending is taken at once.
    always_comb begin
        qual_req = irq_req_in & enable_ff &
                   {NUM_SRC{~mask_ff | (insn_done_in & rti_exec_in)}};
    end

    // Fixed priority pick among qualified requests.
    seic_arbiter u_arb (
        .req_in  (qual_req),
        .any_out (hw_any),
        .vec_out (hw_vec)
    );

    // Recovery timer for stop exit.
    seic_recovery u_rec (
        .core_clk_in (core_clk_in),
        .nrst_in     (nrst_in),
        .run_in      (state_ff == SEIC_RECOVER),
        .short_in    (control_ff[CTL_SHORT_STOP_RECOVERY]),
        .done_out    (rec_done)
    );

    // A wake event: a raw enabled request ignores the mask because wait and
    // stop already cleared it; break also wakes.
    always_comb begin
        wake = (|(irq_req_in & enable_ff)) | break_req_in;
    end

    // Next-state logic.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SEIC_RUN: begin
                if (insn_done_in) begin
                    if (wait_exec_in) begin
                        nxt_state = SEIC_WAIT;
                    end else if (stop_exec_in) begin
                        nxt_state = SEIC_STOP;
                    end else if (soft_int_exec_in || break_req_in || hw_any) begin
                        nxt_state = SEIC_ENTRY;
                    end
                end
            end
            SEIC_ENTRY: begin
                if (stack_done_in) begin
                    nxt_state = SEIC_RUN;
                end
            end
            SEIC_WAIT: begin
                if (wake) begin
                    nxt_state = SEIC_ENTRY;
                end
            end
            SEIC_STOP: begin
                if (wake) begin
                    nxt_state = SEIC_RECOVER;
                end
            end
            SEIC_RECOVER: begin
                if (rec_done) begin
                    nxt_state = SEIC_ENTRY;
                end
            end
            default: begin
                nxt_state = SEIC_RUN;
            end
        endcase
        if (sys_reset_req_in) begin
            nxt_state = SEIC_RUN;
        end
    end

    // State register.
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            state_ff <= SEIC_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Vector selection is latched once and held through stacking, so a
    // later higher-priority request cannot steal an entry in progress.
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            vec_ff      <= VEC_RESET;
            pc_minus_ff <= 1'b0;
            take_ff     <= 1'b0;
        end else begin
            take_ff <= 1'b0;
            if (sys_reset_req_in) begin
                vec_ff      <= VEC_RESET;
                pc_minus_ff <= 1'b0;
                take_ff     <= 1'b1;
            end else if (nxt_state == SEIC_ENTRY && state_ff != SEIC_ENTRY) begin
                take_ff <= 1'b1;
                if (soft_int_exec_in && state_ff == SEIC_RUN) begin
                    vec_ff      <= VEC_SOFT_INT;
                    pc_minus_ff <= 1'b0;
                end else if (break_req_in) begin
                    vec_ff      <= VEC_SOFT_INT;
                    pc_minus_ff <= 1'b1;
                end else begin
                    vec_ff      <= hw_vec;
                    pc_minus_ff <= 1'b1;
                end
            end
        end
    end

    // Global mask: set on entry, cleared by wait, stop and return.
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            mask_ff <= 1'b1;
        end else if (sys_reset_req_in || take_ff) begin
            mask_ff <= 1'b1;
        end else if (insn_done_in && (wait_exec_in || stop_exec_in) &&
                     state_ff == SEIC_RUN) begin
            mask_ff <= 1'b0;
        end else if (insn_done_in && rti_exec_in) begin
            mask_ff <= 1'b0;
        end
    end

    // Break state follows the break request; the wait flag is set on a break
    // in wait or stop, and the set wins over a software clear.
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            break_ff    <= 1'b0;
            bsw_flag_ff <= 1'b0;
        end else begin
            break_ff <= break_req_in;
            if (break_req_in && (state_ff == SEIC_WAIT || state_ff == SEIC_STOP)) begin
                bsw_flag_ff <= 1'b1;
            end else if (wr_en && paddr_in == OFF_STATUS &&
                         pwdata_in[STS_BREAK_DURING_WAIT]) begin
                bsw_flag_ff <= 1'b0;
            end
        end
    end

    // APB decode; the slave answers with no wait states.
    always_comb begin
        addr_ok = (paddr_in == OFF_STAT_ONE) || (paddr_in == OFF_STAT_TWO) ||
                  (paddr_in == OFF_STAT_THREE) || (paddr_in == OFF_ENABLE) ||
                  (paddr_in == OFF_CONTROL) || (paddr_in == OFF_STATUS);
        wr_en   = psel_in & penable_in & pwrite_in & addr_ok;
        rd_en   = psel_in & ~penable_in & ~pwrite_in;
    end

    // Writable configuration registers.
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            enable_ff  <= ENABLE_RST;
            control_ff <= CONTROL_RST;
        end else if (wr_en) begin
            if (paddr_in == OFF_ENABLE) begin
                enable_ff <= pwdata_in[NUM_SRC-1:0];
            end
            if (paddr_in == OFF_CONTROL) begin
                control_ff <= pwdata_in[3:0];
            end
        end
    end

    // Live flag images; flag n sits one bit above n in the joined image, so
    // unused positions stay zero.
    always_comb begin
        logic [23:0] all_flags;
        all_flags = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            all_flags[SRC_FLAG[i]] = irq_req_in[i];
        end
        flag_one   = {all_flags[6:0], 1'b0} & 8'hf4;
        flag_two   = all_flags[14:7];
        flag_three = {7'h00, all_flags[15]};
    end

    // Read data is captured in the setup cycle and shown in the access cycle.
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            rdata_ff <= 32'h0000_0000;
        end else if (rd_en) begin
            case (paddr_in)
                OFF_STAT_ONE:   rdata_ff <= {24'h000000, flag_one};
                OFF_STAT_TWO:   rdata_ff <= {24'h000000, flag_two};
                OFF_STAT_THREE: rdata_ff <= {24'h000000, flag_three};
                OFF_ENABLE:     rdata_ff <= {19'h00000, enable_ff};
                OFF_CONTROL:    rdata_ff <= {28'h0000000, control_ff};
                OFF_STATUS:     rdata_ff <= {28'h0000000, mask_ff,
                                             state_ff == SEIC_STOP || state_ff == SEIC_RECOVER,
                                             state_ff == SEIC_WAIT, bsw_flag_ff};
                default:        rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // Bus answers.
    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~addr_ok;
    assign prdata_out  = rdata_ff;

    // Core-facing controls. The high index register is never stacked.
    assign take_exc_out       = take_ff;
    assign vec_idx_out        = vec_ff;
    assign stack_pc_minus_out = pc_minus_ff;
    assign stack_high_idx_out = 1'b0;
    assign global_mask_out    = mask_ff;

    // Clock gating by state.
    assign core_clk_en_out   = (state_ff == SEIC_RUN) || (state_ff == SEIC_ENTRY);
    assign periph_clk_en_out = (state_ff != SEIC_STOP);
    assign fast_clk_en_out   = (state_ff != SEIC_STOP) ||
                               control_ff[CTL_OSC_ON_IN_STOP];
    assign watchdog_run_out  = ~control_ff[CTL_WATCHDOG_DISABLE] &&
                               (state_ff != SEIC_STOP);

    // Module flags may clear outside break, or in break when enabled; with the
    // enable clear, any clear is refused while break lasts.
    assign break_state_out   = break_ff;
    assign flag_clear_ok_out = ~break_ff | control_ff[CTL_BREAK_CLEAR_ENABLE];

endmodule // seic_ctl

/* logic/seic_pkg.sv */
/*
 * Shared constants for the exception and low-power controller: register
 * offsets, field positions, reset values, source ordering and timing counts.
 * Assumes a 10 MHz core clock that also serves as the fast bus clock.
 */
package seic_pkg;

    // Number of maskable hardware sources, highest priority first.
    localparam int unsigned NUM_SRC = 13;
    // Width of a winning vector index.
    localparam int unsigned IDX_W = 5;

    // Register byte offsets on the APB.
    localparam logic [7:0] OFF_STAT_ONE   = 8'h00;
    localparam logic [7:0] OFF_STAT_TWO   = 8'h04;
    localparam logic [7:0] OFF_STAT_THREE = 8'h08;
    localparam logic [7:0] OFF_ENABLE     = 8'h0c;
    localparam logic [7:0] OFF_CONTROL    = 8'h10;
    localparam logic [7:0] OFF_STATUS     = 8'h14;

    // Control register bit positions.
    localparam int unsigned CTL_BREAK_CLEAR_ENABLE = 0;
    localparam int unsigned CTL_SHORT_STOP_RECOVERY = 1;
    localparam int unsigned CTL_OSC_ON_IN_STOP = 2;
    localparam int unsigned CTL_WATCHDOG_DISABLE = 3;

    // Status register bit positions.
    localparam int unsigned STS_BREAK_DURING_WAIT = 0;
    localparam int unsigned STS_WAIT = 1;
    localparam int unsigned STS_STOP = 2;
    localparam int unsigned STS_GLOBAL_MASK = 3;

    // Reset values.
    localparam logic [12:0] ENABLE_RST  = 13'h0000;
    localparam logic [3:0]  CONTROL_RST = 4'h0;

    // Vector indices: index n selects vector address 16'hfffe - 2*n.
    localparam logic [IDX_W-1:0] VEC_RESET    = 5'h00;
    localparam logic [IDX_W-1:0] VEC_SOFT_INT = 5'h01;

    // Mapping of each source to its flag number and vector index.
    localparam logic [IDX_W-1:0] SRC_FLAG [NUM_SRC] = '{
        5'h01, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h09,
        5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f};
    localparam logic [IDX_W-1:0] SRC_VEC [NUM_SRC] = '{
        5'h02, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0a,
        5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10};

    // Stop recovery times in fast-clock cycles.
    localparam int unsigned STOP_REC_LONG_CYC  = 4096;
    localparam int unsigned STOP_REC_SHORT_CYC = 32;
    localparam int unsigned REC_W = 13;

endpackage : seic_pkg

/* logic/seic_recovery.sv */
/*
 * Stop recovery counter. Held clear while stop is active and not yet
 * recovering; counts fast-clock cycles once recovery starts.
 * Assumes a single core clock and synchronous active-low reset.
 */
module seic_recovery (
    input  wire logic core_clk_in,  // Core clock.
    input  wire logic nrst_in,      // Synchronous reset, active low.
    input  wire logic run_in,       // High while recovery is timing.
    input  wire logic short_in,     // Short recovery selected.
    output logic      done_out      // One-cycle pulse when the time elapses.
);
    import seic_pkg::*;

    localparam logic [REC_W-1:0] LONG_LAST  = REC_W'(STOP_REC_LONG_CYC - 1);
    localparam logic [REC_W-1:0] SHORT_LAST = REC_W'(STOP_REC_SHORT_CYC - 1);

    logic [REC_W-1:0] cnt_ff;  // Elapsed recovery cycles.
    logic             done_ff; // Registered completion pulse.

    // The counter stays at zero outside recovery so each stop starts fresh.
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in || !run_in) begin
            cnt_ff  <= '0;
            done_ff <= 1'b0;
        end else begin
            cnt_ff  <= cnt_ff + REC_W'(1);
            done_ff <= (cnt_ff == (short_in ? SHORT_LAST : LONG_LAST));
        end
    end

    assign done_out = done_ff;

endmodule // seic_recovery

/* testbench/seic_chk.sv */
/* Port checker for the exception and low-power controller.
   Assumes a bind onto seic_ctl; sees only its ports. */
module seic_chk
    import seic_pkg::*;
(
    input wire logic                 core_clk_in,
    input wire logic                 nrst_in,
    input wire logic                 psel_in,
    input wire logic                 penable_in,
    input wire logic                 pwrite_in,
    input wire logic [7:0]           paddr_in,
    input wire logic [31:0]          prdata_out,
    input wire logic [NUM_SRC-1:0]   irq_req_in,
    input wire logic                 sys_reset_req_in,
    input wire logic                 break_req_in,
    input wire logic                 insn_done_in,
    input wire logic                 soft_int_exec_in,
    input wire logic                 wait_exec_in,
    input wire logic                 stop_exec_in,
    input wire logic                 take_exc_out,
    input wire logic [IDX_W-1:0]     vec_idx_out,
    input wire logic                 stack_pc_minus_out,
    input wire logic                 stack_high_idx_out,
    input wire logic                 global_mask_out,
    input wire logic                 core_clk_en_out,
    input wire logic                 break_state_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    // A boundary with no reset or break competing for the same edge.
    sequence s_boundary;
        insn_done_in && !sys_reset_req_in && !break_req_in;
    endsequence
    // Entry pulse followed by the mask being raised.
    sequence s_entry;
        take_exc_out ##1 global_mask_out;
    endsequence
    high_idx_off_a: assert property (!stack_high_idx_out)
        else $error("high index stacking requested");
    reset_vector_a: assert property (sys_reset_req_in |=> take_exc_out && vec_idx_out == VEC_RESET)
        else $error("reset request not taken with vector zero");
    soft_entry_a: assert property (s_boundary ##0 soft_int_exec_in |=>
        take_exc_out && vec_idx_out == VEC_SOFT_INT && !stack_pc_minus_out)
        else $error("software interrupt entry wrong");
    entry_mask_a: assert property (take_exc_out |-> s_entry)
        else $error("mask not set after entry");
    idle_no_take_a: assert property (s_boundary ##0 (irq_req_in == '0 && !soft_int_exec_in)
        |=> !take_exc_out)
        else $error("entry without request");
    low_power_a: assert property (s_boundary ##0 (wait_exec_in || stop_exec_in)
        |=> !global_mask_out && !core_clk_en_out)
        else $error("low power entry did not gate core or clear mask");
    vector_hold_a: assert property (!take_exc_out |-> $stable(vec_idx_out))
        else $error("vector index moved without entry");
    break_state_a: assert property (break_req_in |=> break_state_out)
        else $error("break state not entered");
    stat_one_zero_a: assert property (psel_in && penable_in && !pwrite_in &&
        paddr_in == OFF_STAT_ONE |-> prdata_out[1:0] == 2'h0 && !prdata_out[3])
        else $error("unused status bits not zero");
endmodule // seic_chk

/* testbench/seic_core_model.sv */
/* Behavioural processor core: issues one instruction completion on request
   and reports stacking done two cycles after an entry pulse. */
module seic_core_model (
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic       go_in,
    input  wire logic [2:0] kind_in,
    input  wire logic       take_in,
    output logic            done_out,
    output logic            soft_out,
    output logic            wait_out,
    output logic            stop_out,
    output logic            rti_out,
    output logic            stack_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] stk_ff; // Stacking delay line.
    // Completion strobe and its qualifiers stand for exactly one cycle.
    always_ff @(posedge clk_in) begin
        done_out  <= go_in && nrst_in;
        soft_out  <= go_in && kind_in == 3'h1;
        wait_out  <= go_in && kind_in == 3'h2;
        stop_out  <= go_in && kind_in == 3'h3;
        rti_out   <= go_in && kind_in == 3'h4;
        stk_ff    <= nrst_in ? {stk_ff[0], take_in} : 2'h0;
    end
    assign stack_out = stk_ff[1];
endmodule // seic_core_model

/* testbench/test_seic_ctl.sv */
/* Self-checking bench for seic_ctl with an APB master and a core model.
   Assumes a 10 MHz clock and zero-wait APB answers. */
module test_seic_ctl;
    import seic_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_in = 1'h0, nrst_in = 1'h0, psel_in = 1'h0, penable_in = 1'h0;
    logic pwrite_in = 1'h0, sys_reset_req_in = 1'h0, break_req_in = 1'h0, go = 1'h0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic [12:0] irq_req_in = 13'h0000;
    logic [2:0] kind = 3'h0;
    logic [23:0] img;
    logic pready_out, pslverr_out, insn_done_in, soft_int_exec_in, wait_exec_in, er;
    logic stop_exec_in, rti_exec_in, stack_done_in, take_exc_out, stack_pc_minus_out;
    logic stack_high_idx_out, global_mask_out, core_clk_en_out, periph_clk_en_out;
    logic fast_clk_en_out, watchdog_run_out, break_state_out, flag_clear_ok_out;
    logic [4:0] vec_idx_out;
    int miscompares = 0, comparisons = 0, n;
    always #50 core_clk_in = ~core_clk_in;
    seic_ctl dut (.*);
    seic_core_model core (.clk_in(core_clk_in), .nrst_in(nrst_in), .go_in(go),
        .kind_in(kind), .take_in(take_exc_out), .done_out(insn_done_in),
        .soft_out(soft_int_exec_in), .wait_out(wait_exec_in), .stop_out(stop_exec_in),
        .rti_out(rti_exec_in), .stack_out(stack_done_in));
    // Compare and count; an unknown never matches.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer, held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        psel_in <= 1'h1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge core_clk_in);
        penable_in <= 1'h1;
        do @(posedge core_clk_in); while (pready_out !== 1'h1);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'h0;
        penable_in <= 1'h0;
    endtask
    // Ask the core for one completed instruction of the given kind.
    task automatic op(input logic [2:0] k);
        @(posedge core_clk_in);
        kind <= k;
        go <= 1'h1;
        @(posedge core_clk_in);
        go <= 1'h0;
    endtask
    // Bounded wait for an entry pulse; n counts the edges waited.
    task automatic wtake(input int lim);
        n = 0;
        while (take_exc_out !== 1'h1 && n < lim) begin
            @(posedge core_clk_in);
            n++;
        end
        chk("take", 32'h1, {31'h0, take_exc_out});
    endtask
    task automatic ntake;
        repeat (4) @(posedge core_clk_in) chk("no take", 32'h0, {31'h0, take_exc_out});
    endtask
    task automatic tally_and_finish;
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Watchdog: far beyond the longest recovery plus all sequences.
    initial begin
        #(30000 * 100);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge core_clk_in);
        nrst_in <= 1'h1;
        @(posedge core_clk_in);
        irq_req_in <= 13'h1a5b;
        img = 24'h0;
        for (int i = 0; i < NUM_SRC; i++) img[SRC_FLAG[i] + 5'h01] = |((13'h1a5b >> i) & 13'h0001);
        apb(1'h0, OFF_STAT_ONE, 32'h0);
        chk("stat one", {24'h0, img[7:0] & 8'hf4}, rd);
        apb(1'h0, OFF_STAT_TWO, 32'h0);
        chk("stat two", {24'h0, img[15:8]}, rd);
        apb(1'h0, OFF_STAT_THREE, 32'h0);
        chk("stat three", {24'h0, img[23:16]}, rd);
        apb(1'h0, 8'h40, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        apb(1'h1, OFF_ENABLE, 32'h1fff);
        apb(1'h0, OFF_ENABLE, 32'h0);
        chk("enable", 32'h1fff, rd);
        chk("mask", 32'h1, {31'h0, global_mask_out});
        irq_req_in <= 13'h0000;
        op(3'h4);
        for (int i = 0; i < NUM_SRC; i++) begin
            irq_req_in <= (13'h1 << i) | 13'h1000;
            op(3'h0);
            wtake(8);
            chk("vec", {27'h0, SRC_VEC[i]}, {27'h0, vec_idx_out});
            chk("pc minus", 32'h1, {31'h0, stack_pc_minus_out});
            irq_req_in <= 13'h1000;
            op(3'h4);
            wtake(8);
            chk("vec pend", {27'h0, SRC_VEC[12]}, {27'h0, vec_idx_out});
            irq_req_in <= 13'h0000;
            op(3'h4);
        end
        irq_req_in <= 13'h0001;
        op(3'h0);
        wtake(8);
        op(3'h0);
        ntake();
        op(3'h1);
        wtake(8);
        chk("soft pc", 32'h0, {31'h0, stack_pc_minus_out});
        apb(1'h1, OFF_ENABLE, 32'h0);
        op(3'h4);
        op(3'h0);
        ntake();
        irq_req_in <= 13'h0000;
        apb(1'h1, OFF_ENABLE, 32'h1fff);
        apb(1'h1, OFF_CONTROL, 32'h0);
        op(3'h2);
        repeat (2) @(posedge core_clk_in);
        chk("wait gates", 32'h3, {29'h0, core_clk_en_out, periph_clk_en_out,
            watchdog_run_out});
        irq_req_in <= 13'h0008;
        wtake(4);
        chk("wake vec", {27'h0, SRC_VEC[3]}, {27'h0, vec_idx_out});
        irq_req_in <= 13'h0000;
        op(3'h4);
        op(3'h2);
        @(posedge core_clk_in) break_req_in <= 1'h1;
        @(posedge core_clk_in) break_req_in <= 1'h0;
        wtake(4);
        chk("break vec", {27'h0, VEC_SOFT_INT}, {27'h0, vec_idx_out});
        apb(1'h0, OFF_STATUS, 32'h0);
        chk("break in wait", 32'h1, {31'h0, rd[STS_BREAK_DURING_WAIT]});
        op(3'h4);
        for (int s = 0; s < 2; s++) begin
            apb(1'h1, OFF_CONTROL, s ? 32'h6 : 32'h0);
            op(3'h3);
            repeat (2) @(posedge core_clk_in);
            chk("fast clk", s, {31'h0, fast_clk_en_out});
            irq_req_in <= 13'h0001;
            wtake(5000);
            n = n - (s ? STOP_REC_SHORT_CYC : STOP_REC_LONG_CYC);
            chk("recovery", 32'h1, {31'h0, n >= 0 && n <= 4});
            irq_req_in <= 13'h0000;
            op(3'h4);
        end
        break_req_in <= 1'h1;
        repeat (2) @(posedge core_clk_in);
        chk("clr held", 32'h0, {31'h0, flag_clear_ok_out});
        apb(1'h1, OFF_CONTROL, 32'h1);
        @(posedge core_clk_in) chk("clr on", 32'h1, {31'h0, flag_clear_ok_out});
        break_req_in <= 1'h0;
        apb(1'h1, OFF_CONTROL, 32'h0);
        @(posedge core_clk_in) chk("clr after", 32'h1, {31'h0, flag_clear_ok_out});
        @(posedge core_clk_in) sys_reset_req_in <= 1'h1;
        @(posedge core_clk_in) sys_reset_req_in <= 1'h0;
        wtake(4);
        chk("reset vec", {27'h0, VEC_RESET}, {27'h0, vec_idx_out});
        tally_and_finish();
    end
endmodule // test_seic_ctl
bind seic_ctl seic_chk u_chk (.*);
